/* image_pkg.sv */
// constants and types for the distance and speed process image
package image_pkg;
  // distance resolution choices
  typedef enum logic [2:0] {
    DRES_0P1, DRES_0P125, DRES_1, DRES_10, DRES_100, DRES_FREE
  } dist_res_t;
  // speed resolution choices
  typedef enum logic [2:0] {
    SRES_0P1, SRES_1, SRES_10, SRES_100, SRES_FREE
  } speed_res_t;
  localparam int RES_W = 17; // divisor width in micrometres
  localparam int ACC_W = 48; // internal accumulator width
  localparam int REF_W = 30; // reference field width
  localparam int REL_ADDR_DIST = 0; // byte offset of distance word
  localparam int REL_ADDR_SPEED = 4; // byte offset of speed word
  localparam int BIT_CLR = 30; // clear control bit
  localparam int BIT_SET = 31; // preset control bit
  localparam int REF_MSB = 29; // top bit of reference field
  localparam logic [RES_W-1:0] RES_0P1_UM = 17'h0_0064;
  localparam logic [RES_W-1:0] RES_0P125_UM = 17'h0_007d;
  localparam logic [RES_W-1:0] RES_1_UM = 17'h0_03e8;
  localparam logic [RES_W-1:0] RES_10_UM = 17'h0_2710;
  localparam logic [RES_W-1:0] RES_100_UM = 17'h1_86a0;
  localparam logic [RES_W-1:0] FREE_MIN = 17'h0_0001;
  localparam logic [RES_W-1:0] FREE_MAX = 17'h1_86a0;
  localparam logic [RES_W-1:0] FREE_DIST_DEF = 17'h0_0064;
  localparam logic [RES_W-1:0] FREE_SPEED_DEF = 17'h0_03e8;
  localparam dist_res_t DIST_RES_DEF = DRES_0P1;
  localparam speed_res_t SPEED_RES_DEF = SRES_1;
  localparam logic [5:0] DIV_STEPS = 6'h30; // one step per dividend bit
endpackage

/* div_if.sv */
// request and answer lines between the image logic and its divider
interface div_if;
  logic start; // one-cycle request
  logic signed [47:0] dividend; // sampled by the divider on the start cycle only
  logic [16:0] divisor; // positive micrometre divisor
  logic done; // one-cycle answer
  logic signed [47:0] quotient; // truncated toward zero
  modport client (output start, output dividend, output divisor,
    input done, input quotient);
  modport server (input start, input dividend, input divisor,
    output done, output quotient);
endinterface

/* serial_divider.sv */
// serial signed by unsigned divider, one quotient bit per clock
module serial_divider
  import image_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  div_if.server bus
);
  logic busy_q; // divide in progress
  logic [5:0] cnt_q; // steps left
  logic [ACC_W-1:0] mag_q; // dividend magnitude, shifts into quotient
  logic [RES_W:0] rem_q; // partial remainder
  logic neg_q; // result sign
  logic done_q;
  logic signed [ACC_W-1:0] quo_q;
  wire [RES_W:0] rem_sh = {rem_q[RES_W-1:0], mag_q[ACC_W-1]};
  wire fits = rem_sh >= {1'b0, bus.divisor};
  wire [RES_W:0] rem_sub = rem_sh - {1'b0, bus.divisor};
  wire [ACC_W-1:0] mag_in = bus.dividend[ACC_W-1] ?
    ACC_W'(-bus.dividend) : bus.dividend;
  wire [ACC_W-1:0] mag_nx = {mag_q[ACC_W-2:0], fits};
  // load, then one restoring step per clock; sign fixed at the end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      mag_q <= '0;
      rem_q <= '0;
      neg_q <= 1'b0;
      done_q <= 1'b0;
      quo_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && bus.start) begin
        busy_q <= 1'b1;
        cnt_q <= DIV_STEPS;
        mag_q <= mag_in;
        rem_q <= '0;
        neg_q <= bus.dividend[ACC_W-1];
      end else if (busy_q) begin
        mag_q <= mag_nx;
        rem_q <= fits ? rem_sub : rem_sh;
        cnt_q <= cnt_q - 6'h1;
        if (cnt_q == 6'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          quo_q <= neg_q ? -$signed(mag_nx) : $signed(mag_nx);
        end
      end
    end
  end
  assign bus.done = done_q;
  assign bus.quotient = quo_q;
  // a non-negative quotient times the divisor never exceeds the dividend
  div_bound_a: assert property (@(posedge core_clk) disable iff (reset)
    done_q && !neg_q |-> (quo_q * $signed({31'h0, bus.divisor}))
    <= $signed(bus.dividend)) else $error("quotient too large");
endmodule

/* input_edge_sync.sv */
// two-stage synchroniser with rising-edge pulse for a pin input
module input_edge_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin,
  output logic rise_q
);
  logic meta_q; // first stage, read only by the second
  logic sync_q; // settled level
  logic last_q; // previous settled level
  // capture, settle, then compare settled levels only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= sync_q & ~last_q;
    end
  end
endmodule

/* process_image.sv */
// distance and speed process image with preset and clear control
module process_image (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic signed [31:0] meas_dist_um,
  input wire logic signed [31:0] meas_speed_ums,
  input wire logic meas_ok,
  input wire logic meas_stb,
  input wire logic cfg_load,
  input wire image_pkg::dist_res_t cfg_dist_res,
  input wire logic [16:0] cfg_free_dist_um,
  input wire image_pkg::speed_res_t cfg_speed_res,
  input wire logic [16:0] cfg_free_speed_ums,
  input wire logic [31:0] ctrl_word,
  input wire logic ctrl_stb,
  input wire logic multifunction_input,
  input wire logic nvm_done,
  output logic signed [31:0] image_distance_q,
  output logic signed [31:0] image_speed_q,
  output logic image_stb_q,
  output logic meas_invalid_q,
  output logic image_hold_q,
  output logic nvm_save_q
);
  import image_pkg::*;

  // sequencing of one image update
  typedef enum logic [2:0] {
    ST_IDLE, ST_DIST_GO, ST_DIST_WAIT, ST_SPD_GO, ST_SPD_WAIT, ST_PUB
  } upd_state_t;

  // keep a free divisor inside its legal range
  function automatic logic [RES_W-1:0] clamp_free(
    input logic [RES_W-1:0] v);
    if (v < FREE_MIN) return FREE_MIN;
    if (v > FREE_MAX) return FREE_MAX;
    return v;
  endfunction

  // distance resolution in micrometres
  function automatic logic [RES_W-1:0] dist_div(input dist_res_t s,
    input logic [RES_W-1:0] free_v);
    unique case (s)
      DRES_0P1: return RES_0P1_UM;
      DRES_0P125: return RES_0P125_UM;
      DRES_1: return RES_1_UM;
      DRES_10: return RES_10_UM;
      DRES_100: return RES_100_UM;
      default: return free_v; // free choice and any stray code
    endcase
  endfunction

  // speed resolution in micrometres per second
  function automatic logic [RES_W-1:0] speed_div(input speed_res_t s,
    input logic [RES_W-1:0] free_v);
    unique case (s)
      SRES_0P1: return RES_0P1_UM;
      SRES_1: return RES_1_UM;
      SRES_10: return RES_10_UM;
      SRES_100: return RES_100_UM;
      default: return free_v;
    endcase
  endfunction

  // widen a 32-bit measurement to the accumulator
  function automatic logic signed [ACC_W-1:0] widen(
    input logic signed [31:0] v);
    return ACC_W'(v);
  endfunction

  // configuration, reset to factory settings
  dist_res_t dist_sel_q;
  speed_res_t speed_sel_q;
  logic [RES_W-1:0] free_dist_q;
  logic [RES_W-1:0] free_speed_q;

  // preset state
  logic signed [REF_W-1:0] ref_q; // stored reference, resolution units
  logic signed [ACC_W-1:0] offset_q; // offset in micrometres
  logic prev_clr_q; // last bit 30 seen
  logic prev_set_q; // last bit 31 seen

  // latest sample, captured on its strobe while idle
  logic signed [31:0] dist_raw_q;
  logic signed [31:0] speed_raw_q;
  logic ok_q;
  logic pending_q; // a sample waits for processing

  // update pipeline
  upd_state_t state_q, state_d;
  logic signed [31:0] dist_res_q; // scaled distance, not yet shown
  logic mf_rise; // preset pulse from the pin

  div_if dif();

  serial_divider u_div (
    .core_clk(core_clk),
    .reset(reset),
    .bus(dif.client)
  );

  input_edge_sync u_mf (
    .core_clk(core_clk),
    .reset(reset),
    .pin(multifunction_input),
    .rise_q(mf_rise)
  );

  // divisors currently in force
  wire [RES_W-1:0] dist_div_w = dist_div(dist_sel_q, free_dist_q);
  wire [RES_W-1:0] speed_div_w = speed_div(speed_sel_q, free_speed_q);

  // control edges; clear outranks preset, pin preset is the fallback
  wire clr_edge = ctrl_stb && ctrl_word[BIT_CLR] && !prev_clr_q;
  wire set_edge = ctrl_stb && ctrl_word[BIT_SET] && !prev_set_q;
  wire clr_held = ctrl_stb && ctrl_word[BIT_CLR];
  wire bus_preset = set_edge && !clr_held;
  wire pin_preset = mf_rise && !clr_held;
  wire preset_ev = bus_preset || pin_preset;
  wire change_ev = clr_edge || preset_ev;

  // reference used by a preset: new from the bus, else the stored one
  wire signed [REF_W-1:0] ref_new = bus_preset ?
    $signed(ctrl_word[REF_MSB:0]) : ref_q;
  wire signed [ACC_W-1:0] ref_um = ACC_W'(ref_new) *
    $signed(ACC_W'({1'b0, dist_div_w}));
  wire signed [ACC_W-1:0] preset_off = ref_um - widen(dist_raw_q);

  // divider request lines
  wire dist_go = state_q == ST_DIST_GO;
  wire spd_go = state_q == ST_SPD_GO;
  assign dif.start = dist_go || spd_go;
  assign dif.dividend = (state_q inside {ST_DIST_GO, ST_DIST_WAIT}) ?
    widen(dist_raw_q) + offset_q : widen(speed_raw_q);
  assign dif.divisor = (state_q inside {ST_DIST_GO, ST_DIST_WAIT}) ?
    dist_div_w : speed_div_w;

  // publish only when not saving to flash
  wire can_pub = (state_q == ST_PUB) && !nvm_save_q;

  // next update state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (pending_q) state_d = ST_DIST_GO;
      ST_DIST_GO: state_d = ST_DIST_WAIT;
      ST_DIST_WAIT: if (dif.done) state_d = ST_SPD_GO;
      ST_SPD_GO: state_d = ST_SPD_WAIT;
      ST_SPD_WAIT: if (dif.done) state_d = ST_PUB;
      ST_PUB: if (!nvm_save_q) state_d = ST_IDLE;
    endcase
  end

  // configuration registers; free values clamped on load
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dist_sel_q <= DIST_RES_DEF;
      speed_sel_q <= SPEED_RES_DEF;
      free_dist_q <= FREE_DIST_DEF;
      free_speed_q <= FREE_SPEED_DEF;
    end else if (cfg_load) begin
      dist_sel_q <= cfg_dist_res;
      speed_sel_q <= cfg_speed_res;
      free_dist_q <= clamp_free(cfg_free_dist_um);
      free_speed_q <= clamp_free(cfg_free_speed_ums);
    end
  end

  // sample capture; a sample arriving mid-update is not captured, it only sets pending
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dist_raw_q <= '0;
      speed_raw_q <= '0;
      ok_q <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      if (meas_stb && state_q == ST_IDLE) begin
        dist_raw_q <= meas_dist_um;
        speed_raw_q <= meas_speed_ums;
        ok_q <= meas_ok;
      end
      // new sample wins over the consume in the same cycle
      if (meas_stb) pending_q <= 1'b1;
      else if (state_q == ST_IDLE && pending_q) pending_q <= 1'b0;
    end
  end

  // previous control bits, updated on every exchange and held between
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_clr_q <= 1'b0;
      prev_set_q <= 1'b0;
    end else if (ctrl_stb) begin
      prev_clr_q <= ctrl_word[BIT_CLR];
      prev_set_q <= ctrl_word[BIT_SET];
    end
  end

  // reference and offset; clear first, then preset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_q <= '0;
      offset_q <= '0;
    end else if (clr_edge) begin
      ref_q <= '0;
      offset_q <= '0;
    end else if (preset_ev) begin
      ref_q <= ref_new;
      offset_q <= preset_off;
    end
  end

  // flash save request; a new change while saving keeps it raised
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nvm_save_q <= 1'b0;
    end else if (change_ev) begin
      nvm_save_q <= 1'b1;
    end else if (nvm_done) begin
      nvm_save_q <= 1'b0;
    end
  end

  // update sequence and scaled distance hold
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      dist_res_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_DIST_WAIT && dif.done) begin
        dist_res_q <= dif.quotient[31:0];
      end
    end
  end

  // both words change together, so a reader never mixes updates
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      image_distance_q <= '0;
      image_speed_q <= '0;
      image_stb_q <= 1'b0;
      meas_invalid_q <= 1'b0;
      image_hold_q <= 1'b0;
    end else begin
      image_stb_q <= can_pub;
      image_hold_q <= nvm_save_q;
      if (can_pub) begin
        image_distance_q <= ok_q ? dist_res_q : '0;
        image_speed_q <= ok_q ? $signed(dif.quotient[31:0]) : '0;
        meas_invalid_q <= !ok_q;
      end
    end
  end

  // quotient from the speed step must survive until publish
  // note: divider holds its quotient register until the next divide finishes

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // words only move together with the publish strobe
  image_pair_a: assert property ($changed(image_distance_q) ||
    $changed(image_speed_q) |-> image_stb_q)
    else $error("image word changed without publish");
  // an invalid sample shows zero in both words
  invalid_zero_a: assert property (image_stb_q && meas_invalid_q |->
    image_distance_q == 0 && image_speed_q == 0)
    else $error("invalid sample not zero");
  // clear edge empties reference and offset next cycle
  clear_zero_a: assert property (clr_edge |=> offset_q == 0
    && ref_q == 0)
    else $error("clear left offset");
  clear_wins_a: assert property (clr_held |=>
    offset_q == 0 || $stable(offset_q))
    else $error("preset taken while clear set");
  // offset only moves after a clear or preset event
  offset_cause_a: assert property ($changed(offset_q) |->
    $past(change_ev))
    else $error("offset moved without an edge");
  // a held bit 31 must not preset again
  level_no_preset_a: assert property (ctrl_stb && prev_set_q &&
    !mf_rise && !clr_edge |=> $stable(offset_q))
    else $error("steady bit 31 re-applied preset");
  // offset is reference minus the captured distance
  preset_value_a: assert property (preset_ev && !clr_edge |=>
    offset_q == $past(preset_off))
    else $error("offset not reference minus distance");
  pin_preset_a: assert property (mf_rise && !clr_held && !clr_edge |=>
    offset_q == $past(preset_off))
    else $error("pin preset ignored");
  // every change raises a flash save
  save_req_a: assert property (change_ev |=> nvm_save_q)
    else $error("change not saved");
  save_hold_a: assert property (nvm_save_q |=> !image_stb_q)
    else $error("published during save");
  // previous control bits follow each exchange
  edge_memory_a: assert property (ctrl_stb |=>
    prev_clr_q == $past(ctrl_word[BIT_CLR]) &&
    prev_set_q == $past(ctrl_word[BIT_SET]))
    else $error("control bits not remembered");
  // factory resolutions in force right after reset
  default_res_a: assert property ($fell(reset) |->
    dist_div_w == RES_0P1_UM && speed_div_w == RES_1_UM)
    else $error("factory resolution wrong");

  // each divide answers a fixed count of edges after its request;
  // a config load during a divide would shift the divisor under way
  localparam int DIV_LAT = int'(DIV_STEPS) + 1;
  // distance divide: load edge plus one step per dividend bit
  div_dist_lat_a: assert property (dist_go |-> ##DIV_LAT dif.done)
    else $error("distance divide late");
  // speed divide has the same fixed latency
  div_spd_lat_a: assert property (spd_go |-> ##DIV_LAT dif.done)
    else $error("speed divide late");
  // published distance is the held quotient, untouched
  pub_dist_a: assert property (can_pub && ok_q |=>
    image_distance_q == $past(dist_res_q))
    else $error("distance word not the quotient");
  // published speed is the quotient still held by the divider
  pub_speed_a: assert property (can_pub && ok_q |=>
    image_speed_q == $past(dif.quotient[31:0]))
    else $error("speed word not the quotient");
  // status follows the sample that was just published
  pub_status_a: assert property (can_pub |=>
    meas_invalid_q == !$past(ok_q))
    else $error("status does not match sample");
  // the publish strobe never stretches over two cycles
  stb_pulse_a: assert property (image_stb_q |=> !image_stb_q)
    else $error("publish strobe too long");
  // pause flag trails the save request by one cycle
  hold_follow_a: assert property (image_hold_q == $past(nvm_save_q))
    else $error("pause flag out of step");
  // a finished save drops the request unless a new change came in
  save_end_a: assert property (nvm_save_q && nvm_done && !change_ev
    |=> !nvm_save_q)
    else $error("save request stuck");
  // a sample strobe is never lost, even in mid-update
  sample_kept_a: assert property (meas_stb |=> pending_q)
    else $error("sample strobe lost");

  // main scenarios
  preset_c: cover property (bus_preset ##[1:200] image_stb_q);
  clear_c: cover property (clr_edge ##1 nvm_save_q);
  free_res_c: cover property (dist_sel_q == DRES_FREE && image_stb_q);
  invalid_c: cover property (image_stb_q && meas_invalid_q);
  pin_c: cover property (pin_preset ##1 nvm_save_q);
endmodule

/* fieldbus_host.sv */
// controller-side model: sends control words and answers flash saves
module fieldbus_host (
  input wire logic core_clk,
  input wire logic nvm_save_q,
  output logic [31:0] ctrl_word,
  output logic ctrl_stb,
  output logic nvm_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int save_wait = 2; // flash writer delay, set by the bench before each control word

  initial begin
    ctrl_word = 32'h0000_0000;
    ctrl_stb = 1'b0;
    nvm_done = 1'b0;
  end

  // one-cycle word transfer; word is scrambled once the strobe drops
  task automatic send_word(input logic b31, input logic b30,
      input logic [29:0] ref_v);
    @(posedge core_clk);
    ctrl_word <= {b31, b30, ref_v};
    ctrl_stb <= 1'b1;
    @(posedge core_clk);
    ctrl_word <= ~{b31, b30, ref_v};
    ctrl_stb <= 1'b0;
  endtask

  // flash writer: pulses nvm_done for one cycle, save_wait clocks after a request
  always begin
    @(posedge core_clk);
    if (nvm_save_q === 1'b1) begin
      repeat (save_wait) @(posedge core_clk);
      nvm_done <= 1'b1;
      @(posedge core_clk);
      nvm_done <= 1'b0;
    end
  end
endmodule

/* test_distance_speed_process_image.sv */
// self-checking bench for the distance and speed process image
module test_distance_speed_process_image;
  timeunit 1ns;
  timeprecision 100ps;
  import image_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic signed [31:0] meas_dist_um, meas_speed_ums;
  logic meas_ok, meas_stb, cfg_load, multifunction_input;
  dist_res_t cfg_dist_res;
  speed_res_t cfg_speed_res;
  logic [16:0] cfg_free_dist_um, cfg_free_speed_ums;
  logic [31:0] ctrl_word;
  logic ctrl_stb, nvm_done;
  logic signed [31:0] image_distance_q, image_speed_q;
  logic image_stb_q, meas_invalid_q, image_hold_q, nvm_save_q;
  int bad_count = 0;
  int n_tests = 0;
  integer seed = 32'h71f6_e822; // fixed so runs repeat
  longint dres_um = 100; // expected divisors and offset, in um
  longint sres_um = 1000;
  longint off_um = 0;
  longint ref_r = 0;
  longint last_d = 0; // last captured distance
  logic [29:0] r;
  logic [16:0] fd, fs;

  always #12.5 core_clk = ~core_clk;

  process_image i_dut (.core_clk(core_clk), .reset(reset),
    .meas_dist_um(meas_dist_um), .meas_speed_ums(meas_speed_ums),
    .meas_ok(meas_ok), .meas_stb(meas_stb), .cfg_load(cfg_load),
    .cfg_dist_res(cfg_dist_res), .cfg_free_dist_um(cfg_free_dist_um),
    .cfg_speed_res(cfg_speed_res),
    .cfg_free_speed_ums(cfg_free_speed_ums), .ctrl_word(ctrl_word),
    .ctrl_stb(ctrl_stb), .multifunction_input(multifunction_input),
    .nvm_done(nvm_done), .image_distance_q(image_distance_q),
    .image_speed_q(image_speed_q), .image_stb_q(image_stb_q),
    .meas_invalid_q(meas_invalid_q), .image_hold_q(image_hold_q),
    .nvm_save_q(nvm_save_q));

  fieldbus_host i_host (.core_clk(core_clk), .nvm_save_q(nvm_save_q),
    .ctrl_word(ctrl_word), .ctrl_stb(ctrl_stb), .nvm_done(nvm_done));

  // free divisors outside the legal span are pulled to its ends
  function automatic longint lim_free(logic [16:0] f);
    if (f < FREE_MIN) return FREE_MIN;
    if (f > FREE_MAX) return FREE_MAX;
    return f;
  endfunction

  // divisor in micrometres for each resolution code
  function automatic longint dist_div(dist_res_t c, logic [16:0] f);
    case (c)
      DRES_0P1: return RES_0P1_UM;
      DRES_0P125: return RES_0P125_UM;
      DRES_1: return RES_1_UM;
      DRES_10: return RES_10_UM;
      DRES_100: return RES_100_UM;
      default: return lim_free(f);
    endcase
  endfunction

  function automatic longint spd_div(speed_res_t c, logic [16:0] f);
    case (c)
      SRES_0P1: return RES_0P1_UM;
      SRES_1: return RES_1_UM;
      SRES_10: return RES_10_UM;
      SRES_100: return RES_100_UM;
      default: return lim_free(f);
    endcase
  endfunction

  // truncating division, low word kept
  function automatic logic [31:0] scale(longint v, longint d);
    longint q;
    q = v / d;
    return q[31:0];
  endfunction

  function automatic logic [16:0] rnd_free();
    return 17'(1 + ($unsigned($random(seed)) % 100000));
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // publication waits on the divider and any flash save
  task automatic wait_pub();
    for (int i = 0; i < 600; i++) begin
      @(negedge core_clk);
      if (image_stb_q === 1'b1) return;
    end
    bad_count++;
    $display("ERROR %0t no image update", $time);
    tally_and_finish();
  endtask

  // one measurement in, both words compared against the model
  task automatic sample(input longint d, input longint s, input logic ok);
    @(posedge core_clk);
    meas_dist_um <= 32'(d);
    meas_speed_ums <= 32'(s);
    meas_ok <= ok;
    meas_stb <= 1'b1;
    @(posedge core_clk);
    meas_stb <= 1'b0;
    meas_dist_um <= ~32'(d);
    last_d = d;
    wait_pub();
    check(image_distance_q, ok ? scale(d + off_um, dres_um) : 0);
    check(image_speed_q, ok ? scale(s, sres_um) : 0);
    check(32'(meas_invalid_q), 32'(!ok));
    @(negedge core_clk);
    check(32'(image_stb_q), 0);
  endtask

  task automatic set_cfg(input dist_res_t dr, input logic [16:0] fdv,
      input speed_res_t sr, input logic [16:0] fsv);
    @(posedge core_clk);
    cfg_dist_res <= dr;
    cfg_free_dist_um <= fdv;
    cfg_speed_res <= sr;
    cfg_free_speed_ums <= fsv;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    dres_um = dist_div(dr, fdv);
    sres_um = spd_div(sr, fsv);
  endtask

  // watches for a save and its output pause, then lets it finish
  task automatic watch(input logic save);
    logic seen;
    logic held;
    seen = 1'b0;
    held = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk);
      if (seen && image_hold_q === 1'b1) held = 1'b1;
      if (nvm_save_q === 1'b1) seen = 1'b1;
    end
    check(32'(seen), 32'(save));
    check(32'(held), 32'(save));
    for (int i = 0; i < 100 && nvm_save_q !== 1'b0; i++) begin
      @(negedge core_clk);
    end
    check(32'(nvm_save_q), 0);
    if (nvm_save_q !== 1'b0) tally_and_finish();
  endtask

  task automatic ctrl(input logic b31, input logic b30, input logic save);
    i_host.save_wait = 2 + ($unsigned($random(seed)) % 39);
    i_host.send_word(b31, b30, r);
    watch(save);
  endtask

  function automatic longint rnd_v();
    return longint'($random(seed) >>> 8);
  endfunction

  // main sequence
  initial begin
    {meas_dist_um, meas_speed_ums, meas_ok, meas_stb} = '0;
    {cfg_load, multifunction_input, cfg_free_dist_um} = '0;
    cfg_dist_res = DIST_RES_DEF;
    cfg_speed_res = SPEED_RES_DEF;
    cfg_free_speed_ums = FREE_SPEED_DEF;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check(image_distance_q, 0);
    check({image_stb_q, meas_invalid_q, image_hold_q, nvm_save_q}, 0);
    repeat (3) sample(rnd_v(), rnd_v(), 1'b1);
    // every resolution code, free distance divisor at its low limit, free speed divisor at its high
    for (int c = 0; c < 12; c++) begin
      fd = (c == 5) ? 17'h0_0001 : rnd_free();
      if (c == 11) fd = 17'h0_0000;
      fs = (c == 4) ? FREE_MAX : rnd_free();
      if (c == 9) fs = 17'h1_ffff;
      set_cfg(dist_res_t'(c % 6), fd, speed_res_t'(c % 5), fs);
      sample(rnd_v(), rnd_v(), 1'b1);
    end
    sample(rnd_v(), rnd_v(), 1'b0);
    set_cfg(DIST_RES_DEF, FREE_DIST_DEF, SPEED_RES_DEF, FREE_SPEED_DEF);
    sample(rnd_v(), rnd_v(), 1'b1);
    // preset to a random signed reference, then same position
    r = 30'($random(seed) % 4000);
    ctrl(1'b1, 1'b0, 1'b1);
    ref_r = longint'($signed(r));
    off_um = ref_r * dres_um - last_d;
    sample(last_d, rnd_v(), 1'b1);
    check(image_distance_q, {{2{r[29]}}, r});
    ctrl(1'b1, 1'b0, 1'b0);
    ctrl(1'b0, 1'b0, 1'b0);
    sample(rnd_v(), rnd_v(), 1'b1);
    // pin preset reuses the stored reference
    @(posedge core_clk);
    multifunction_input <= 1'b1;
    watch(1'b1);
    off_um = ref_r * dres_um - last_d;
    multifunction_input <= 1'b0;
    sample(rnd_v(), rnd_v(), 1'b1);
    // clear wins over a simultaneous preset edge
    ctrl(1'b1, 1'b1, 1'b1);
    off_um = 0;
    sample(rnd_v(), rnd_v(), 1'b1);
    ctrl(1'b0, 1'b1, 1'b0);
    ctrl(1'b1, 1'b1, 1'b0);
    sample(rnd_v(), rnd_v(), 1'b1);
    tally_and_finish();
  end
endmodule
